//--- rtl/capture_compare_timer_ctrl.sv
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "capture_compare_timer_regs.svh"

// Operation
// R1 - Counter counts only while run bit set
// R2 - Dual mode stop bit halts on match A
// R3 - Buffer B pairs register D behind B
// R4 - Buffer A pairs register C behind A
// R5 - Mode bit selects dual-compare, ignores io settings
// R6 - PWM select puts channel B-D in PWM
// R7 - Clear bit clears counter on match A
// R8 - Clock select picks system or divided clock
// R9 - Code 101 counts external rising edges
// R10 - Subclock state replaces undivided system clock
// R11 - Software keeps oscillator, stops before reselect
// R12 - Level bit sets B-D start, PWM polarity
// R13 - Level bit sets A until first match
// R14 - Level bit writes reach pin immediately; the code drives the pin only for level bits whose value changes
// R15 - Trigger edge field only in dual mode
// R16 - Overflow request needs flag and enable
// R17 - Channel request needs flag and enable
// R18 - Overflow flag sets on wrap to zero
// R19 - Flag clears by zero write after read
// R20 - Compare equality sets channel flag
// R21 - Capture into register sets channel flag
// R22 - PWM or dual mode equality sets flag
// R23 - Reserved bits always read as one
// R24 - Sixteen bit counter, full access, reset zero
module capture_compare_timer_ctrl (
    input wire logic clk,                     // System clock
    input wire logic sys_rst,                 // Synchronous reset, active high
    input wire logic wb_cyc_i,                // Bus cycle
    input wire logic wb_stb_i,                // Bus strobe
    input wire logic wb_we_i,                 // Write enable
    input wire logic [7:0] wb_adr_i,          // Byte address
    input wire logic [3:0] wb_sel_i,          // Byte lanes
    input wire logic [31:0] wb_dat_i,         // Write data
    output logic [31:0] wb_dat_o,             // Read data
    output logic wb_ack_o,                    // Acknowledge
    input wire logic subclock_mode,           // Chip in subclock low-power state
    input wire logic subclock_tick,           // One pulse per subclock period
    input wire logic fast_osc_tick,           // One pulse per fast oscillator period
    input wire logic ext_count_pin,           // External count input
    input wire logic ext_trigger_pin,         // External trigger input
    input wire logic [3:0] channel_pin_in,    // Channel pins D..A, input level
    output logic [3:0] channel_pin_out,       // Channel pins D..A, output level
    output logic [3:0] channel_pin_oe_n,      // Low while the pin is driven
    output logic overflow_irq,                // Overflow request
    output logic match_irq_a,                 // Channel A request
    output logic match_irq_b,                 // Channel B request
    output logic match_irq_c,                 // Channel C request
    output logic match_irq_d                  // Channel D request
);

    capture_compare_timer_pkg::timer_state_t st_r;
    capture_compare_timer_pkg::timer_state_t st_nxt;

    // Merge written byte lanes into a 16 bit value
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // Edge test on a sampled pin for a two bit edge code
    function automatic logic edge_hit(input logic prev, input logic now, input logic [1:0] e);
        edge_hit = ((e == `EDGE_RISE || e == `EDGE_BOTH) && !prev && now)
                || ((e == `EDGE_FALL || e == `EDGE_BOTH) && prev && !now);
    endfunction

    // Decoded controls
    logic run;
    logic dual;
    logic [2:0] cks;
    logic tick;
    logic req;
    logic wr;
    logic rd;
    logic [3:0] is_cap;
    logic [3:0] own_evt;
    logic [3:0] match;
    logic [3:0] cap;
    logic [3:0] chan_set;
    logic [3:0] lvl;
    logic trig;
    logic cnt_wrap;
    logic [7:0] clr_req;

    assign run = st_r.mode[`MODE_RUN];
    assign dual = !st_r.mode[`MODE_DUAL_N];
    assign cks = st_r.clk_clr_lvl[`CCL_CKS_HI:`CCL_CKS_LO];
    assign lvl = st_r.clk_clr_lvl[`CCL_LVL_HI:`CCL_LVL_LO];
    assign req = wb_cyc_i && wb_stb_i;
    // Writes land at the edge where the master sees ack
    assign wr = req && st_r.ack && wb_we_i;
    assign rd = req && !st_r.ack && !wb_we_i;

    // Count source; a stopped counter ignores every tick
    always_comb
    begin
        case (cks)
            `CKS_SYS: tick = subclock_mode ? subclock_tick : 1'b1; // R8 R10
            `CKS_DIV2: tick = &st_r.div[0:0]; // R8
            `CKS_DIV4: tick = &st_r.div[1:0]; // R8
            `CKS_DIV8: tick = &st_r.div[2:0]; // R8
            `CKS_DIV32: tick = &st_r.div[4:0]; // R8
            `CKS_EXT: tick = ext_count_pin && !st_r.ext_prev; // R9
            `CKS_FAST: tick = fast_osc_tick; // R8
            default: tick = 1'b0; // Reserved code never counts
        endcase
        tick = tick && run; // R1
    end

    // Channel events: compare on a counting edge, capture on a pin edge
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            // Dual-compare mode forces every channel to compare
            is_cap[i] = !dual && st_r.io_ctrl[4*i+`IO_CAP]; // R5
            match[i] = tick && (st_r.cnt == st_r.gr[i]) && !is_cap[i]; // R20 R22
            cap[i] = is_cap[i] && (st_r.io_ctrl[4*i+1] ? (st_r.pin_prev[i] != channel_pin_in[i])
                : edge_hit(st_r.pin_prev[i], channel_pin_in[i],
                           st_r.io_ctrl[4*i] ? `EDGE_FALL : `EDGE_RISE)); // R21
        end
        // A buffering register raises no flags or captures; its match still drives its pin in PWM mode
        own_evt = {!st_r.mode[`MODE_BUF_B], !st_r.mode[`MODE_BUF_A], 2'b11}; // R3 R4
        chan_set = (match | cap) & own_evt; // R20 R21 R22
        cnt_wrap = tick && (st_r.cnt == `CNT_MAX)
                && !(st_r.clk_clr_lvl[`CCL_CLEAR] && match[0]); // R18
        trig = dual && edge_hit(st_r.trig_prev, ext_trigger_pin,
                                st_r.trig_stop[`TS_EDGE_HI:`TS_EDGE_LO]); // R15
    end

    // Next state of the whole block
    always_comb
    begin
        st_nxt = st_r;
        clr_req = 8'h00;
        st_nxt.div = st_r.div + 5'h01;
        st_nxt.ext_prev = ext_count_pin;
        st_nxt.trig_prev = ext_trigger_pin;
        st_nxt.pin_prev = channel_pin_in;
        st_nxt.ack = req && !st_r.ack;

        // Counter: clear on match A or free run with wrap
        if (tick)
        begin
            if (st_r.clk_clr_lvl[`CCL_CLEAR] && match[0])
                st_nxt.cnt = `CNT_RESET; // R7
            else
                st_nxt.cnt = st_r.cnt + 16'h0001; // R24
        end

        // Trigger edge restarts counting in dual-compare mode
        if (trig)
            st_nxt.mode[`MODE_RUN] = 1'b1; // R15
        // Stop on match A only applies in dual-compare mode
        if (dual && st_r.trig_stop[`TS_STOP] && match[0])
            st_nxt.mode[`MODE_RUN] = 1'b0; // R2

        // Captures, with paired buffer taking the old value
        for (int i = 0; i < 2; i++)
        begin
            if (cap[i])
            begin
                if (st_r.mode[`MODE_BUF_A + i])
                    st_nxt.gr[i+2] = st_r.gr[i]; // R3 R4
                st_nxt.gr[i] = st_r.cnt; // R21
            end
            else if (match[i] && st_r.mode[`MODE_BUF_A + i])
                st_nxt.gr[i] = st_r.gr[i+2]; // R3 R4
        end
        for (int i = 2; i < 4; i++)
        begin
            if (cap[i] && own_evt[i])
                st_nxt.gr[i] = st_r.cnt; // R21
        end

        // Pin outputs
        if (dual)
        begin
            // Channel B pulses between match B and match A
            if (match[1])
                st_nxt.pin_out[1] = !lvl[1]; // R5
            if (match[0])
                st_nxt.pin_out[1] = lvl[1]; // R5
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (i > 0 && st_r.mode[`MODE_PWM_B + i - 1])
                begin
                    // PWM: level bit sets polarity, period from match A
                    if (match[0])
                        st_nxt.pin_out[i] = lvl[i]; // R6 R12
                    if (match[i])
                        st_nxt.pin_out[i] = !lvl[i]; // R6 R12
                end
                else if (match[i] && own_evt[i])
                begin
                    case (st_r.io_ctrl[4*i +: 2])
                        `ACT_ZERO: st_nxt.pin_out[i] = 1'b0;
                        `ACT_ONE: st_nxt.pin_out[i] = 1'b1;
                        `ACT_TOGGLE: st_nxt.pin_out[i] = !st_r.pin_out[i];
                        default: st_nxt.pin_out[i] = st_r.pin_out[i];
                    endcase
                end
            end
        end

        // Flags are set by hardware events
        st_nxt.flags[`OVF_BIT] = st_r.flags[`OVF_BIT] || cnt_wrap; // R18
        st_nxt.flags[3:0] = st_r.flags[3:0] | chan_set;

        // Bus reads: latch data, arm flags read as one
        if (rd && wb_adr_i == `OFS_STATUS)
            st_nxt.armed = st_r.armed | (st_r.flags & `FLAG_MASK); // R19

        // Bus writes: software write wins over counting on the same edge
        if (wr)
        begin
            case (wb_adr_i)
                `OFS_MODE:
                    if (wb_sel_i[0])
                        st_nxt.mode = wb_dat_i[7:0] & ~`MODE_RSVD; // R1
                `OFS_CLK_CLR_LVL:
                    if (wb_sel_i[0])
                    begin
                        st_nxt.clk_clr_lvl = wb_dat_i[7:0]; // R11
                        for (int i = 0; i < 4; i++)
                        begin
                            // A changed level bit drives the pin at once
                            if (wb_dat_i[`CCL_LVL_LO + i] != lvl[i])
                                st_nxt.pin_out[i] = wb_dat_i[`CCL_LVL_LO + i]; // R13 R14
                        end
                    end
                `OFS_TRIG_STOP:
                    if (wb_sel_i[0])
                        st_nxt.trig_stop = wb_dat_i[7:0] & ~`TS_RSVD;
                `OFS_IRQ_EN:
                    if (wb_sel_i[0])
                        st_nxt.irq_en = wb_dat_i[7:0] & ~`IRQ_RSVD;
                `OFS_STATUS:
                    if (wb_sel_i[0])
                    begin
                        // Zero clears only a flag armed by a read
                        clr_req = ~wb_dat_i[7:0] & st_r.armed & `FLAG_MASK; // R19
                        st_nxt.armed = 8'h00;
                    end
                `OFS_COUNTER:
                    // Partial writes would tear the counter, so they are dropped
                    if (wb_sel_i[1:0] == 2'b11)
                        st_nxt.cnt = wb_dat_i[15:0]; // R24
                `OFS_GR_A: st_nxt.gr[0] = merge16(st_r.gr[0], wb_dat_i, wb_sel_i);
                `OFS_GR_B: st_nxt.gr[1] = merge16(st_r.gr[1], wb_dat_i, wb_sel_i);
                `OFS_GR_C: st_nxt.gr[2] = merge16(st_r.gr[2], wb_dat_i, wb_sel_i);
                `OFS_GR_D: st_nxt.gr[3] = merge16(st_r.gr[3], wb_dat_i, wb_sel_i);
                `OFS_IO_CTRL: st_nxt.io_ctrl = merge16(st_r.io_ctrl, wb_dat_i, wb_sel_i);
                default: st_nxt.mode = st_nxt.mode; // Unmapped writes ignored
            endcase
        end
        // A new event in the clearing cycle keeps its flag
        st_nxt.flags = (st_r.flags & ~clr_req) | {cnt_wrap, 3'b000, chan_set}; // R19

        // Read data captured as ack rises
        st_nxt.rdata = 32'h0000_0000;
        if (rd)
        begin
            case (wb_adr_i)
                `OFS_MODE: st_nxt.rdata[7:0] = st_r.mode | `MODE_RSVD; // R23
                `OFS_CLK_CLR_LVL: st_nxt.rdata[7:0] = st_r.clk_clr_lvl;
                `OFS_TRIG_STOP: st_nxt.rdata[7:0] = st_r.trig_stop | `TS_RSVD; // R23
                `OFS_IRQ_EN: st_nxt.rdata[7:0] = st_r.irq_en | `IRQ_RSVD; // R23
                `OFS_STATUS: st_nxt.rdata[7:0] = st_r.flags | `IRQ_RSVD; // R23
                `OFS_COUNTER: st_nxt.rdata[15:0] = st_r.cnt; // R24
                `OFS_GR_A: st_nxt.rdata[15:0] = st_r.gr[0];
                `OFS_GR_B: st_nxt.rdata[15:0] = st_r.gr[1];
                `OFS_GR_C: st_nxt.rdata[15:0] = st_r.gr[2];
                `OFS_GR_D: st_nxt.rdata[15:0] = st_r.gr[3];
                `OFS_IO_CTRL: st_nxt.rdata[15:0] = st_r.io_ctrl;
                default: st_nxt.rdata = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // Register the whole state
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r.mode <= `MODE_RESET;
            st_r.clk_clr_lvl <= `CCL_RESET;
            st_r.trig_stop <= `TS_RESET;
            st_r.irq_en <= `IRQ_RESET;
            st_r.flags <= 8'h00;
            st_r.armed <= 8'h00;
            st_r.io_ctrl <= `IO_RESET;
            st_r.cnt <= `CNT_RESET; // R24
            st_r.gr <= {4{`GR_RESET}};
            st_r.pin_out <= 4'h0;
            st_r.pin_prev <= 4'h0;
            st_r.div <= `DIV_RESET;
            st_r.ext_prev <= 1'b0;
            st_r.trig_prev <= 1'b0;
            st_r.ack <= 1'b0;
            st_r.rdata <= 32'h0000_0000;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs; capture channels release their pins
    assign wb_dat_o = st_r.rdata;
    assign wb_ack_o = st_r.ack;
    assign channel_pin_out = st_r.pin_out;
    assign channel_pin_oe_n = {is_cap[3:2], is_cap[1] && !dual, is_cap[0] || dual};
    assign overflow_irq = st_r.flags[`OVF_BIT] && st_r.irq_en[`OVF_BIT]; // R16
    assign match_irq_a = st_r.flags[0] && st_r.irq_en[0]; // R17
    assign match_irq_b = st_r.flags[1] && st_r.irq_en[1]; // R17
    assign match_irq_c = st_r.flags[2] && st_r.irq_en[2]; // R17
    assign match_irq_d = st_r.flags[3] && st_r.irq_en[3]; // R17

endmodule

//--- shared/capture_compare_timer_pkg.sv
package capture_compare_timer_pkg;

    // Whole state of the timer in one record
    typedef struct packed {
        logic [7:0] mode;          // Run, buffer, mode bits
        logic [7:0] clk_clr_lvl;   // Clear, clock select, initial levels
        logic [7:0] trig_stop;     // Trigger edge and stop on match
        logic [7:0] irq_en;        // Interrupt enables
        logic [7:0] flags;         // Status flags
        logic [7:0] armed;         // Flags seen as 1 by a status read
        logic [15:0] io_ctrl;      // Per channel compare/capture control
        logic [15:0] cnt;          // Main counter
        logic [3:0][15:0] gr;      // General registers A..D
        logic [3:0] pin_out;       // Channel pin output levels
        logic [3:0] pin_prev;      // Last sampled channel pin levels
        logic [4:0] div;           // Free running prescaler
        logic ext_prev;            // Last sampled external count pin
        logic trig_prev;           // Last sampled trigger pin
        logic ack;                 // Bus acknowledge
        logic [31:0] rdata;        // Bus read data
    } timer_state_t;

endpackage

//--- shared/capture_compare_timer_regs.svh
`ifndef CAPTURE_COMPARE_TIMER_REGS_SVH
`define CAPTURE_COMPARE_TIMER_REGS_SVH

// Register byte offsets on the bus
`define OFS_MODE 8'h00
`define OFS_CLK_CLR_LVL 8'h04
`define OFS_TRIG_STOP 8'h08
`define OFS_IRQ_EN 8'h0C
`define OFS_STATUS 8'h10
`define OFS_COUNTER 8'h14
`define OFS_GR_A 8'h18
`define OFS_GR_B 8'h1C
`define OFS_GR_C 8'h20
`define OFS_GR_D 8'h24
`define OFS_IO_CTRL 8'h28

// Mode register fields
`define MODE_RUN 7
`define MODE_BUF_B 5
`define MODE_BUF_A 4
`define MODE_DUAL_N 3
`define MODE_PWM_D 2
`define MODE_PWM_C 1
`define MODE_PWM_B 0
`define MODE_RESET 8'h08
`define MODE_RSVD 8'h40

// Clock, clear and initial level fields
`define CCL_CLEAR 7
`define CCL_CKS_HI 6
`define CCL_CKS_LO 4
`define CCL_LVL_HI 3
`define CCL_LVL_LO 0
`define CCL_RESET 8'h00

// Clock select codes
`define CKS_SYS 3'h0
`define CKS_DIV2 3'h1
`define CKS_DIV4 3'h2
`define CKS_DIV8 3'h3
`define CKS_DIV32 3'h4
`define CKS_EXT 3'h5
`define CKS_FAST 3'h6

// Trigger and stop fields
`define TS_EDGE_HI 7
`define TS_EDGE_LO 6
`define TS_STOP 5
`define TS_RESET 8'h00
`define TS_RSVD 8'h1F
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

// Interrupt enable and status layout
`define OVF_BIT 7
`define IRQ_RESET 8'h00
`define IRQ_RSVD 8'h70
`define FLAG_MASK 8'h8F

// Per channel io nibble: bit 3 capture select, bits 1:0 action or edge
`define IO_CAP 3
`define IO_RESET 16'h0000
`define ACT_ZERO 2'h1
`define ACT_ONE 2'h2
`define ACT_TOGGLE 2'h3

`define CNT_RESET 16'h0000
`define CNT_MAX 16'hFFFF
`define GR_RESET 16'hFFFF
`define DIV_RESET 5'h00

`endif

//--- testbench/capture_compare_timer_monitor.sv
`timescale 1ns/1ns
`include "capture_compare_timer_regs.svh"

module capture_compare_timer_monitor (
    input wire logic clk,               // System clock
    input wire logic sys_rst,           // Synchronous reset
    input wire logic wb_cyc_i,          // Bus cycle
    input wire logic wb_stb_i,          // Bus strobe
    input wire logic wb_we_i,           // Write enable
    input wire logic [7:0] wb_adr_i,    // Byte address
    input wire logic [3:0] wb_sel_i,    // Byte lanes
    input wire logic [31:0] wb_dat_i,   // Write data
    input wire logic [31:0] wb_dat_o,   // Read data
    input wire logic wb_ack_o,          // Acknowledge
    input wire logic [3:0] channel_pin_out, // Pin levels
    input wire logic overflow_irq,      // Overflow request
    input wire logic match_irq_a,       // Channel A request
    input wire logic match_irq_b,       // Channel B request
    input wire logic match_irq_c,       // Channel C request
    input wire logic match_irq_d        // Channel D request
);
    logic [7:0] en_r;  // Shadow of the enables
    logic [3:0] lvl_r; // Shadow of the initial levels
    logic [3:0] chg_r; // Level bits flipped by the last write
    logic rd_ack;      // Read answered now
    logic wr_ack;      // Byte write lands at this edge
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];

    // Shadows move at the ack edge, the same edge the slave commits
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            en_r <= 8'h00;
            lvl_r <= 4'h0;
            chg_r <= 4'h0;
        end
        else if (wr_ack && wb_adr_i == `OFS_IRQ_EN)
            en_r <= wb_dat_i[7:0];
        else if (wr_ack && wb_adr_i == `OFS_CLK_CLR_LVL)
        begin
            lvl_r <= wb_dat_i[3:0];
            chg_r <= wb_dat_i[3:0] ^ lvl_r;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without a request");
    a_rsvd_mode: assert property (rd_ack && wb_adr_i == `OFS_MODE |-> wb_dat_o[6])
        else $error("mode reserved bit read as zero");
    a_rsvd_trig: assert property (
        rd_ack && wb_adr_i == `OFS_TRIG_STOP |-> wb_dat_o[4:0] == 5'h1F)
        else $error("trigger reserved bits read wrong");
    a_rsvd_irq: assert property (rd_ack && (wb_adr_i == `OFS_IRQ_EN ||
        wb_adr_i == `OFS_STATUS) |-> wb_dat_o[6:4] == 3'h7)
        else $error("interrupt reserved bits read wrong");
    a_ovf_gate: assert property (overflow_irq |-> en_r[7])
        else $error("overflow request while disabled");
    a_match_gate: assert property (
        ({match_irq_d, match_irq_c, match_irq_b, match_irq_a} & ~en_r[3:0]) == 4'h0)
        else $error("channel request while disabled");
    a_level_now: assert property (wr_ack && wb_adr_i == `OFS_CLK_CLR_LVL |=>
        ((channel_pin_out ^ lvl_r) & chg_r) == 4'h0)
        else $error("level write not on the pin");
    a_unmapped_zero: assert property (rd_ack && wb_adr_i > `OFS_IO_CTRL |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");

    c_overflow: cover property (overflow_irq);
    c_match_a: cover property (match_irq_a);
    c_unmapped: cover property (rd_ack && wb_adr_i > `OFS_IO_CTRL);
endmodule

bind capture_compare_timer_ctrl capture_compare_timer_monitor u_capture_compare_timer_monitor (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .channel_pin_out(channel_pin_out),
    .overflow_irq(overflow_irq), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b),
    .match_irq_c(match_irq_c), .match_irq_d(match_irq_d));

//--- testbench/pulse_source.sv
`timescale 1ns/1ns

module pulse_source (
    input wire logic clk,              // System clock
    input wire logic go,               // Start a burst
    input wire logic [7:0] count,      // Rising edges in the burst
    output logic ext_count_pin,        // External count input
    input wire logic [3:0] pin_out,    // Timer pin levels
    input wire logic [3:0] pin_oe_n,   // Low while timer drives
    output logic [3:0] pin_in          // Level seen on the pins
);
    logic [9:0] left = 10'h000; // Quarter periods still to send

    // Two cycles high, two low, so every edge is seen by a sampler
    always @(posedge clk)
    begin
        if (go)
            left <= {count, 2'h0};
        else if (left != 10'h000)
            left <= left - 10'h001;
        ext_count_pin <= (left != 10'h000) && left[1];
    end
    initial ext_count_pin = 1'b0;

    // Released pins fall to the load's pull-down
    assign pin_in = ~pin_oe_n & pin_out;
endmodule

//--- testbench/test_capture_compare_timer_ctrl.sv
`timescale 1ns/1ns
`include "capture_compare_timer_regs.svh"

module test_capture_compare_timer_ctrl;
    logic clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus side
    logic sub_mode = 1'b0, sub_tick = 1'b0, fast_tick = 1'b0, go = 1'b0; // Sources
    logic [7:0] adr = 8'h00, pcount = 8'h00; // Address, burst size
    logic [3:0] sel = 4'hF; // Whole words always
    logic [31:0] dat = 32'h0, q, dat_o; // Write, last read, bus read
    logic ack, ext_pin, ovf_irq; // Design answers and the burst pin
    logic [3:0] p_out, p_oe_n, p_in, m_irq; // Pins and requests
    int mismatches = 0, comparisons = 0, cyc_n = 0, i;
    logic [2:0] cks_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6}; // Sources
    int exp_tab [6] = '{67, 33, 17, 8, 2, 22}; // Counts over the window

    always #20 clk = ~clk;
    // Slow ticks: fast oscillator every 3rd cycle, subclock every 5th
    always @(posedge clk)
    begin
        cyc_n <= cyc_n + 1;
        fast_tick <= (cyc_n % 3 == 0);
        sub_tick <= (cyc_n % 5 == 0);
    end

    capture_compare_timer_ctrl u_capture_compare_timer_ctrl (.clk(clk), .sys_rst(sys_rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .subclock_mode(sub_mode),
        .subclock_tick(sub_tick), .fast_osc_tick(fast_tick), .ext_count_pin(ext_pin),
        .ext_trigger_pin(ext_pin), .channel_pin_in(p_in), .channel_pin_out(p_out),
        .channel_pin_oe_n(p_oe_n), .overflow_irq(ovf_irq), .match_irq_a(m_irq[0]),
        .match_irq_b(m_irq[1]), .match_irq_c(m_irq[2]), .match_irq_d(m_irq[3]));
    pulse_source u_pulse_source (.clk(clk), .go(go), .count(pcount), .ext_count_pin(ext_pin),
        .pin_out(p_out), .pin_oe_n(p_oe_n), .pin_in(p_in));

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One classic cycle; held until ack, then one idle cycle
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
            chk("ack", 32'h1, 32'h0);
        @(posedge clk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, exp, q);
    endtask

    // Window of counting; the counter is halted before reselecting
    task rate(input logic [2:0] cks, input int exp);
        wb(1'b1, `OFS_MODE, 32'h08);
        wb(1'b1, `OFS_CLK_CLR_LVL, {25'h0, cks, 4'h0});
        wb(1'b1, `OFS_COUNTER, 32'h0);
        wb(1'b1, `OFS_MODE, 32'h88);
        repeat (64) @(posedge clk);
        wb(1'b1, `OFS_MODE, 32'h08);
        wb(1'b0, `OFS_COUNTER, 32'h0);
        chk("count rate", 32'h1, {31'h0, int'(q) >= exp - 1 && int'(q) <= exp + 1});
    endtask

    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(`OFS_MODE, 32'h48, "mode");
        rd(`OFS_TRIG_STOP, 32'h1F, "trigger");
        rd(`OFS_IRQ_EN, 32'h70, "enables");
        rd(`OFS_STATUS, 32'h70, "status");
        rd(`OFS_COUNTER, 32'h0, "counter");
        rd(8'h3C, 32'h0, "unmapped");
        wb(1'b1, `OFS_COUNTER, 32'h1234);
        repeat (10) @(posedge clk);
        rd(`OFS_COUNTER, 32'h1234, "held counter");
        for (i = 0; i < 6; i++)
            rate(cks_tab[i], exp_tab[i]);
        sub_mode <= 1'b1;
        rate(3'h0, 13);
        sub_mode <= 1'b0;
        // External edges only
        wb(1'b1, `OFS_CLK_CLR_LVL, 32'h50);
        wb(1'b1, `OFS_COUNTER, 32'h0);
        wb(1'b1, `OFS_MODE, 32'h88);
        pcount <= 8'h07;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (40) @(posedge clk);
        wb(1'b1, `OFS_MODE, 32'h08);
        rd(`OFS_COUNTER, 32'h7, "edge count");
        // Wrap past the top with the request enabled
        wb(1'b1, `OFS_CLK_CLR_LVL, 32'h00);
        wb(1'b1, `OFS_COUNTER, 32'hFFF0);
        wb(1'b1, `OFS_IRQ_EN, 32'h80);
        wb(1'b1, `OFS_MODE, 32'h88);
        repeat (30) @(posedge clk);
        wb(1'b1, `OFS_MODE, 32'h08);
        chk("overflow irq", 32'h1, {31'h0, ovf_irq});
        wb(1'b1, `OFS_IRQ_EN, 32'h00);
        chk("masked irq", 32'h0, {31'h0, ovf_irq});
        wb(1'b1, `OFS_IRQ_EN, 32'h80);
        wb(1'b1, `OFS_STATUS, 32'h00);
        chk("unread clear", 32'h1, {31'h0, ovf_irq});
        rd(`OFS_STATUS, 32'hFF, "status ovf");
        wb(1'b1, `OFS_STATUS, 32'h00);
        chk("read clear", 32'h0, {31'h0, ovf_irq});
        // Compare A toggles the pin and clears the counter
        wb(1'b1, `OFS_IO_CTRL, 32'h0003);
        wb(1'b1, `OFS_GR_A, 32'h0005);
        wb(1'b1, `OFS_COUNTER, 32'h0);
        wb(1'b1, `OFS_CLK_CLR_LVL, 32'h80);
        wb(1'b1, `OFS_IRQ_EN, 32'h01);
        wb(1'b1, `OFS_MODE, 32'h88);
        repeat (20) @(posedge clk);
        wb(1'b1, `OFS_MODE, 32'h08);
        rd(`OFS_COUNTER, 32'h5, "counter");
        chk("cleared count", 32'h1, {31'h0, q <= 32'h5});
        chk("irq a", 32'h1, {31'h0, m_irq[0]});
        rd(`OFS_STATUS, 32'h71, "status a");
        // Level writes reach the pins at once
        wb(1'b1, `OFS_CLK_CLR_LVL, 32'h0F);
        chk("pins high", 32'hF, {28'h0, p_out});
        wb(1'b1, `OFS_CLK_CLR_LVL, 32'h0A);
        chk("pins mixed", 32'hA, {28'h0, p_out});
        // Dual compare mode halts on match A
        wb(1'b1, `OFS_TRIG_STOP, 32'h60);
        wb(1'b1, `OFS_CLK_CLR_LVL, 32'h00);
        wb(1'b1, `OFS_COUNTER, 32'h0);
        wb(1'b1, `OFS_MODE, 32'h80);
        go <= 1'b1;
        repeat (30) @(posedge clk);
        go <= 1'b0;
        rd(`OFS_MODE, 32'h40, "stopped mode");
        rd(`OFS_COUNTER, 32'h6, "counter");
        chk("stop count", 32'h1, {31'h0, q == 32'h5 || q == 32'h6});
        rd(`OFS_MODE, 32'hC0, "trig run");
        conclude();
    end
endmodule
